// >>> rtl/rtcl_pkg.sv
// constants and types for the clock status and write-lock logic
package rtcl_pkg;

  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned TICK_HZ     = 32_768;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam logic [11:0] TICK_LAST   = 12'(TICK_CYCLES - 1);

  localparam logic [7:0] OFS_SECONDS  = 8'h00;
  localparam logic [7:0] OFS_PRESCALE = 8'h04;
  localparam logic [7:0] OFS_ALARM    = 8'h08;
  localparam logic [7:0] OFS_COMP     = 8'h0C;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_LOCK     = 8'h18;

  localparam int ST_RUN   = 4;
  localparam int ST_ALARM = 2;
  localparam int ST_OVF   = 1;
  localparam int ST_INV   = 0;

  localparam int CT_SWR = 0;
  localparam int CT_UM  = 3;

  localparam int LOCK_LSB   = 3;
  localparam int NUM_LOCKS  = 4;
  localparam int LK_COMP    = 0;
  localparam int LK_CTRL    = 1;
  localparam int LK_STATUS  = 2;
  localparam int LK_LOCKREG = 3;

  localparam logic [31:0] LOCK_FIXED   = 32'h0000_0087;
  localparam logic [15:0] PRESCALE_TOP = 16'h7FFF;
  localparam logic [31:0] SECONDS_TOP  = 32'hFFFF_FFFF;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  localparam logic [15:0] HALF_ZERO    = 16'h0000;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rtcl_av_req_t;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction : merge

endpackage : rtcl_pkg

// >>> rtl/rtcl_tick_div.sv
// divider giving one-cycle time base enable pulses
`timescale 1ns/1ps
module rtcl_tick_div (
  input  wire logic mclk,
  input  wire logic rst_n,
  output logic      tick
);

  logic [11:0] count;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 12'h000;
      tick  <= 1'b0;
    end else if (count == rtcl_pkg::TICK_LAST) begin
      count <= 12'h000;
      tick  <= 1'b1;
    end else begin
      count <= count + 12'h001;
      tick  <= 1'b0;
    end
  end

endmodule : rtcl_tick_div

// >>> rtl/rtcl_lock_bit.sv
// one write-once-to-zero lock bit
`timescale 1ns/1ps
module rtcl_lock_bit (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic restore,
  input  wire logic clear,
  output logic      q
);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b1;
    end else if (restore) begin
      q <= 1'b1;
    end else if (clear) begin
      q <= 1'b0;
    end
  end

endmodule : rtcl_lock_bit

// >>> rtl/rtcl_top.sv
// clock status flags, time counter and write-lock register
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module rtcl_top (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire rtcl_pkg::rtcl_av_req_t av_req,
  output logic [31:0]                 av_readdata,
  output logic                        av_waitrequest,
  output logic                        counter_run_bit,
  output logic                        alarm_flag,
  output logic                        overflow_flag,
  output logic                        invalid_flag
);

  logic [31:0]                   seconds_counter;
  logic [15:0]                   prescaler_counter;
  logic [31:0]                   alarm_compare_value;
  logic [31:0]                   comp_value;
  logic                          soft_reset_bit;
  logic                          update_mode_bit;
  logic [rtcl_pkg::NUM_LOCKS-1:0] lock_q;
  logic [rtcl_pkg::NUM_LOCKS-1:0] lock_restore;
  logic [rtcl_pkg::NUM_LOCKS-1:0] lock_clear;
  logic                          tick;
  logic                          wr_acc;
  logic                          rd_start;
  logic [31:0]                   wval;
  logic                          counting;
  logic                          presc_wrap;
  logic                          sec_inc;
  logic                          sec_wrap;
  logic                          blanked;
  logic                          wr_seconds;
  logic                          wr_prescale;
  logic                          wr_alarm;
  logic                          wr_comp;
  logic                          wr_ctrl;
  logic                          wr_status;
  logic                          wr_lock;
  logic                          run_write_ok;
  logic                          run_wr;
  logic                          ctrl_wr;
  logic                          alarm_hit;
  logic [31:0]                   presc_merged;
  logic [31:0]                   next_readdata;

  wire lock_reg_protect     = lock_q[rtcl_pkg::LK_LOCKREG];
  wire status_protect       = lock_q[rtcl_pkg::LK_STATUS];
  wire control_protect      = lock_q[rtcl_pkg::LK_CTRL];
  wire compensation_protect = lock_q[rtcl_pkg::LK_COMP];

  rtcl_tick_div u_div (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // bus handshake: one wait cycle, then accept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      av_waitrequest <= 1'b1;
    end else if (av_req.read || av_req.write) begin
      av_waitrequest <= !av_waitrequest;
    end else begin
      av_waitrequest <= 1'b1;
    end
  end

  assign wr_acc   = av_req.write && !av_waitrequest;
  assign rd_start = av_req.read && av_waitrequest;
  assign wval     = rtcl_pkg::merge(zero_word(), av_req.writedata,
                                    av_req.byteenable);

  function automatic logic [31:0] zero_word();
    zero_word = rtcl_pkg::WORD_ZERO;
  endfunction : zero_word

  // per register write strobes
  always_comb begin
    wr_seconds  = 1'b0;
    wr_prescale = 1'b0;
    wr_alarm    = 1'b0;
    wr_comp     = 1'b0;
    wr_ctrl     = 1'b0;
    wr_status   = 1'b0;
    wr_lock     = 1'b0;
    if (wr_acc) begin
      case (av_req.address)
        rtcl_pkg::OFS_SECONDS:  wr_seconds  = 1'b1;
        rtcl_pkg::OFS_PRESCALE: wr_prescale = 1'b1;
        rtcl_pkg::OFS_ALARM:    wr_alarm    = 1'b1;
        rtcl_pkg::OFS_COMP:     wr_comp     = 1'b1;
        rtcl_pkg::OFS_CTRL:     wr_ctrl     = 1'b1;
        rtcl_pkg::OFS_STATUS:   wr_status   = 1'b1;
        rtcl_pkg::OFS_LOCK:     wr_lock     = 1'b1;
        default:                wr_acc_none();
      endcase
    end
  end

  function automatic void wr_acc_none();
  endfunction : wr_acc_none

  // counters held while the overflow or invalid flag is set
  assign counting   = counter_run_bit && !overflow_flag && !invalid_flag;
  assign blanked    = overflow_flag || invalid_flag;
  assign presc_wrap = prescaler_counter == rtcl_pkg::PRESCALE_TOP;
  assign sec_inc    = counting && tick && presc_wrap;
  assign sec_wrap   = seconds_counter == rtcl_pkg::SECONDS_TOP;
  // match seen at the increment edge
  assign alarm_hit  = sec_inc && alarm_compare_value == seconds_counter;

  // prescaler keeps lanes that are not enabled
  assign presc_merged = rtcl_pkg::merge({rtcl_pkg::HALF_ZERO,
                                         prescaler_counter},
                                        av_req.writedata,
                                        av_req.byteenable);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_counter <= rtcl_pkg::HALF_ZERO;
    end else if (soft_reset_bit) begin
      prescaler_counter <= rtcl_pkg::HALF_ZERO;
    end else if (!counter_run_bit && wr_prescale) begin
      prescaler_counter <= presc_merged[15:0];
    end else if (counting && tick && presc_wrap) begin
      prescaler_counter <= rtcl_pkg::HALF_ZERO;
    end else if (counting && tick) begin
      prescaler_counter <= prescaler_counter + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seconds_counter <= rtcl_pkg::WORD_ZERO;
    end else if (soft_reset_bit) begin
      seconds_counter <= rtcl_pkg::WORD_ZERO;
    end else if (!counter_run_bit && wr_seconds) begin
      seconds_counter <= rtcl_pkg::merge(seconds_counter,
                                         av_req.writedata,
                                         av_req.byteenable);
    end else if (sec_inc) begin
      seconds_counter <= seconds_counter + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_compare_value <= rtcl_pkg::WORD_ZERO;
    end else if (soft_reset_bit) begin
      alarm_compare_value <= rtcl_pkg::WORD_ZERO;
    end else if (wr_alarm) begin
      alarm_compare_value <= rtcl_pkg::merge(alarm_compare_value,
                                             av_req.writedata,
                                             av_req.byteenable);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_flag <= 1'b0;
    end else if (soft_reset_bit) begin
      alarm_flag <= 1'b0;
    end else if (alarm_hit) begin
      alarm_flag <= 1'b1;
    end else if (wr_alarm) begin
      alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (soft_reset_bit) begin
      overflow_flag <= 1'b0;
    end else if (sec_inc && sec_wrap) begin
      overflow_flag <= 1'b1;
    end else if (wr_seconds && !counter_run_bit) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      invalid_flag <= 1'b1;
    end else if (soft_reset_bit) begin
      invalid_flag <= 1'b1;
    end else if (wr_seconds && !counter_run_bit) begin
      invalid_flag <= 1'b0;
    end
  end

  // update mode opens the run bit while the counter is stopped or blanked
  assign run_write_ok = status_protect ||
                        (update_mode_bit &&
                         (blanked || !counter_run_bit));
  // only the run bit takes status writes
  assign run_wr  = wr_status && run_write_ok && av_req.byteenable[0];

  // control writes need the control lock open
  assign ctrl_wr = wr_ctrl && control_protect && av_req.byteenable[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      counter_run_bit <= 1'b0;
    end else if (soft_reset_bit) begin
      counter_run_bit <= 1'b0;
    // only the run bit is writable
    end else if (run_wr) begin
      counter_run_bit <= av_req.writedata[rtcl_pkg::ST_RUN];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      comp_value <= rtcl_pkg::WORD_ZERO;
    end else if (soft_reset_bit) begin
      comp_value <= rtcl_pkg::WORD_ZERO;
    end else if (wr_comp && compensation_protect) begin
      comp_value <= rtcl_pkg::merge(comp_value, av_req.writedata,
                                    av_req.byteenable);
    end
  end

  // soft reset bit survives its own reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_bit <= 1'b0;
    end else if (ctrl_wr) begin
      soft_reset_bit <= av_req.writedata[rtcl_pkg::CT_SWR];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      update_mode_bit <= 1'b0;
    end else if (soft_reset_bit) begin
      update_mode_bit <= 1'b0;
    end else if (ctrl_wr) begin
      update_mode_bit <= av_req.writedata[rtcl_pkg::CT_UM];
    end
  end

  // lock bits only cleared by writes
  always_comb begin
    for (int i = 0; i < rtcl_pkg::NUM_LOCKS; i++) begin
      lock_clear[i]   = wr_lock && lock_reg_protect &&
                        !wval[rtcl_pkg::LOCK_LSB + i];
      lock_restore[i] = soft_reset_bit;
    end
    lock_restore[rtcl_pkg::LK_CTRL] = 1'b0;
  end

  genvar g;
  generate
    for (g = 0; g < rtcl_pkg::NUM_LOCKS; g++) begin : g_lock
      rtcl_lock_bit u_lock (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .restore (lock_restore[g]),
        .clear   (lock_clear[g]),
        .q       (lock_q[g])
      );
    end
  endgenerate

  // read data mux
  always_comb begin
    next_readdata = rtcl_pkg::WORD_ZERO;
    case (av_req.address)
      rtcl_pkg::OFS_SECONDS:
        next_readdata = blanked ? rtcl_pkg::WORD_ZERO : seconds_counter;
      rtcl_pkg::OFS_PRESCALE:
        next_readdata[15:0] = blanked ? rtcl_pkg::HALF_ZERO
                                      : prescaler_counter;
      rtcl_pkg::OFS_ALARM:
        next_readdata = alarm_compare_value;
      rtcl_pkg::OFS_COMP:
        next_readdata = comp_value;
      rtcl_pkg::OFS_CTRL: begin
        next_readdata[rtcl_pkg::CT_SWR] = soft_reset_bit;
        next_readdata[rtcl_pkg::CT_UM]  = update_mode_bit;
      end
      rtcl_pkg::OFS_STATUS: begin
        next_readdata[rtcl_pkg::ST_RUN]   = counter_run_bit;
        next_readdata[rtcl_pkg::ST_ALARM] = alarm_flag;
        next_readdata[rtcl_pkg::ST_OVF]   = overflow_flag;
        next_readdata[rtcl_pkg::ST_INV]   = invalid_flag;
      end
      rtcl_pkg::OFS_LOCK: begin
        next_readdata = rtcl_pkg::LOCK_FIXED;
        next_readdata[rtcl_pkg::LOCK_LSB +: rtcl_pkg::NUM_LOCKS] = lock_q;
      end
      default:
        next_readdata = rtcl_pkg::WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      av_readdata <= rtcl_pkg::WORD_ZERO;
    end else if (rd_start) begin
      av_readdata <= next_readdata;
    end
  end

endmodule : rtcl_top

// >>> tb/rtcl_monitor.sv
// port assertions for the clock status and write-lock block
`timescale 1ns/1ps
module rtcl_monitor (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire rtcl_pkg::rtcl_av_req_t av_req,
  input wire logic [31:0]            av_readdata,
  input wire logic                   av_waitrequest,
  input wire logic                   counter_run_bit,
  input wire logic                   alarm_flag,
  input wire logic                   overflow_flag,
  input wire logic                   invalid_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic       req;
  logic       rd_ok;
  logic       wr_ok;
  logic [7:0] adr;
  assign req   = av_req.read | av_req.write;
  assign rd_ok = av_req.read & !av_waitrequest;
  assign wr_ok = av_req.write & !av_waitrequest;
  assign adr   = av_req.address;

  wait_answer_a: assert property (req && av_waitrequest |=> !av_waitrequest)
    else $error("no answer one cycle after request");
  wait_one_a: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("wait low longer than one cycle");
  idle_wait_a: assert property (!req |=> av_waitrequest)
    else $error("wait low without request");
  reset_flags_a: assert property (
    !$past(rst_n) |-> invalid_flag && !counter_run_bit && !overflow_flag)
    else $error("flags wrong after reset");
  ovf_clear_a: assert property (
    $fell(overflow_flag) |->
      $past(wr_ok && adr == rtcl_pkg::OFS_SECONDS && !counter_run_bit) ||
      $past(wr_ok && adr == rtcl_pkg::OFS_CTRL, 2))
    else $error("overflow flag cleared without cause");
  inv_clear_a: assert property (
    $fell(invalid_flag) |->
      $past(wr_ok && adr == rtcl_pkg::OFS_SECONDS && !counter_run_bit))
    else $error("invalid flag cleared without cause");
  run_change_a: assert property (
    $changed(counter_run_bit) |->
      $past(wr_ok && adr == rtcl_pkg::OFS_STATUS) ||
      $past(wr_ok && adr == rtcl_pkg::OFS_CTRL, 2))
    else $error("run bit changed without write");
  alarm_clear_a: assert property (
    $fell(alarm_flag) |->
      $past(wr_ok && adr == rtcl_pkg::OFS_ALARM) ||
      $past(wr_ok && adr == rtcl_pkg::OFS_CTRL, 2))
    else $error("alarm flag cleared without cause");
  blank_read_a: assert property (
    rd_ok && (adr == rtcl_pkg::OFS_SECONDS || adr == rtcl_pkg::OFS_PRESCALE)
      && $past(overflow_flag || invalid_flag) |-> av_readdata == 32'h0)
    else $error("counter read not zero while blanked");
  sr_rsvd_a: assert property (
    rd_ok && adr == rtcl_pkg::OFS_STATUS |->
      av_readdata[31:5] == 27'h0 && !av_readdata[3])
    else $error("status reserved bits not zero");
  lr_fixed_a: assert property (
    rd_ok && adr == rtcl_pkg::OFS_LOCK |-> av_readdata[31:8] == 24'h0
      && av_readdata[7] && av_readdata[2:0] == 3'h7)
    else $error("lock fixed bits wrong");

  cover property (wr_ok);
  cover property ($rose(overflow_flag));
  cover property ($rose(alarm_flag));
endmodule : rtcl_monitor

bind rtcl_top rtcl_monitor u_rtcl_monitor (.mclk(mclk), .rst_n(rst_n),
  .av_req(av_req), .av_readdata(av_readdata),
  .av_waitrequest(av_waitrequest), .counter_run_bit(counter_run_bit),
  .alarm_flag(alarm_flag), .overflow_flag(overflow_flag),
  .invalid_flag(invalid_flag));

// >>> tb/tb.sv
// testbench for the clock status and write-lock block
`timescale 1ns/1ps
module tb;
  logic                   mclk;
  logic                   rst_n;
  rtcl_pkg::rtcl_av_req_t req;
  logic [31:0]            rdata;
  logic                   wreq;
  int                     fails;
  int                     n_checks;
  logic                   run_o;
  logic                   alarm_o;
  logic                   ovf_o;
  logic                   inv_o;
  logic [31:0]            flags;

  rtcl_top u_rtcl_top (.mclk(mclk), .rst_n(rst_n), .av_req(req),
    .av_readdata(rdata), .av_waitrequest(wreq), .counter_run_bit(run_o),
    .alarm_flag(alarm_o), .overflow_flag(ovf_o), .invalid_flag(inv_o));

  assign flags = {27'h0, run_o, 1'h0, alarm_o, ovf_o, inv_o};

  always #5 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    req <= '{~w, w, a, d, 4'hF};
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rdc

  task automatic t_reset;
    rdc(8'h14, 32'h0000_0001);
    chk(flags, 32'h0000_0001);
    rdc(8'h18, 32'h0000_00FF);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h40, 32'h0000_0000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_count;
    wr(8'h08, 32'h0000_0005);
    wr(8'h00, 32'h0000_0005);
    rdc(8'h14, 32'h0000_0000);
    wr(8'h04, 32'h0000_7FFE);
    rdc(8'h00, 32'h0000_0005);
    wr(8'h14, 32'h0000_0010);
    wr(8'h00, 32'h0000_0009);
    repeat (7000) @(posedge mclk);
    rdc(8'h00, 32'h0000_0006);
    rdc(8'h14, 32'h0000_0014);
    chk(flags, 32'h0000_0014);
    wr(8'h08, 32'h0000_0000);
    rdc(8'h14, 32'h0000_0010);
    wr(8'h14, 32'h0000_0000);
    $display("t_count done");
  endtask : t_count

  task automatic t_ovf;
    wr(8'h00, 32'hFFFF_FFFF);
    wr(8'h04, 32'h0000_7FFF);
    wr(8'h14, 32'h0000_0010);
    repeat (3200) @(posedge mclk);
    rdc(8'h14, 32'h0000_0012);
    chk(flags, 32'h0000_0012);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0000);
    wr(8'h14, 32'h0000_0007);
    rdc(8'h14, 32'h0000_0002);
    wr(8'h00, 32'h0000_0003);
    rdc(8'h14, 32'h0000_0000);
    rdc(8'h00, 32'h0000_0003);
    rdc(8'h04, 32'h0000_0000);
    $display("t_ovf done");
  endtask : t_ovf

  task automatic t_lock;
    wr(8'h0C, 32'h0000_00A5);
    rdc(8'h0C, 32'h0000_00A5);
    wr(8'h18, 32'h0000_00DF);
    wr(8'h14, 32'h0000_0010);
    rdc(8'h14, 32'h0000_0000);
    wr(8'h18, 32'h0000_00FF);
    rdc(8'h18, 32'h0000_00DF);
    wr(8'h10, 32'h0000_0008);
    wr(8'h14, 32'h0000_0010);
    rdc(8'h14, 32'h0000_0010);
    wr(8'h14, 32'h0000_0000);
    rdc(8'h14, 32'h0000_0010);
    wr(8'h10, 32'h0000_0009);
    rdc(8'h10, 32'h0000_0001);
    wr(8'h10, 32'h0000_0000);
    rdc(8'h14, 32'h0000_0001);
    rdc(8'h18, 32'h0000_00FF);
    wr(8'h18, 32'h0000_00E7);
    wr(8'h0C, 32'h0000_0055);
    rdc(8'h0C, 32'h0000_0000);
    wr(8'h10, 32'h0000_0008);
    rdc(8'h10, 32'h0000_0000);
    wr(8'h18, 32'h0000_00A7);
    wr(8'h18, 32'h0000_0087);
    rdc(8'h18, 32'h0000_00A7);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(8'h18, 32'h0000_00FF);
    rdc(8'h14, 32'h0000_0001);
    chk(flags, 32'h0000_0001);
    wr(8'h10, 32'h0000_0001);
    wr(8'h18, 32'h0000_00EF);
    rdc(8'h18, 32'h0000_00EF);
    $display("t_lock done");
  endtask : t_lock

  task automatic close_out;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    close_out();
  end

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    fails = 0;
    n_checks = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_count();
    t_ovf();
    t_lock();
    close_out();
  end
endmodule : tb
